// ---- design/ssr_flag_latch.sv ----
// sticky event flags with write-one-to-clear
// assumes set and clear are synchronous single-cycle requests
`timescale 1ns/10ps

module ssr_flag_latch
#(
	parameter int W = 8
)
(
	// clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         resetn_i,
	// events and clears
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	// flags
	output logic      [W-1:0] q_o
);

	// ------------------------------------------------------------
	// latch
	// ------------------------------------------------------------
	// set beats clear so an event in the clear cycle survives
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			q_o <= '0;
		end
		else
		begin
			q_o <= (q_o & ~clr_i) | set_i;
		end
	end

endmodule

// ---- design/ssr_pkg.sv ----
// supervisor register bank: shared constants, field positions and carriers
// assumes one 250 MHz clock and a synchronous active-low reset
package ssr_pkg;

	// ------------------------------------------------------------
	// register offsets (5-bit serial address)
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_RAIL_HEALTH  = 5'h01;
	localparam logic [4:0] ADDR_PIN_WDOG     = 5'h02;
	localparam logic [4:0] ADDR_FIVE_V_LATCH = 5'h03;
	localparam logic [4:0] ADDR_CORE_LATCH   = 5'h04;
	localparam logic [4:0] ADDR_INT_LATCH    = 5'h05;
	localparam logic [4:0] ADDR_SHUTOFF      = 5'h06;
	localparam logic [4:0] ADDR_UNLOCK       = 5'h07;
	localparam logic [4:0] ADDR_WDOG_CFG     = 5'h08;

	// ------------------------------------------------------------
	// reset values and implemented-bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] WDOG_CFG_RST      = 8'h24;
	localparam logic [7:0] SHUTOFF_RST       = 8'h00;
	localparam logic [7:0] SHUTOFF_MASK      = 8'hee;
	localparam logic [7:0] INT_LATCH_MASK    = 8'h0f;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int OFF_PROT_HI = 7;   // protected rail pair, upper bit
	localparam int OFF_A_HI    = 6;
	localparam int OFF_B_HI    = 5;
	localparam int OFF_PROT_LO = 3;   // protected rail pair, lower bit
	localparam int OFF_A_LO    = 2;
	localparam int OFF_B_LO    = 1;
	localparam int A_OVER      = 7;   // five volt latch positions
	localparam int A_UNDER     = 6;
	localparam int PROT_OVER   = 3;
	localparam int PROT_UNDER  = 2;
	localparam int B_OVER      = 1;
	localparam int B_UNDER     = 0;
	localparam int SEL_HI      = 7;   // watchdog type select
	localparam int SEL_LO      = 6;
	localparam int UPPER_HI    = 5;   // pulse upper offset code
	localparam int UPPER_LO    = 3;
	localparam int LOWER_HI    = 2;   // pulse lower offset code
	localparam int LOWER_LO    = 0;

	// ------------------------------------------------------------
	// unlock key words
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_WORD1         = 8'hd3;
	localparam logic [7:0] KEY_WORD2         = 8'h33;
	localparam logic [7:0] KEY_FLASH         = 8'hcc;
	localparam logic [7:0] KEY_RESTART       = 8'hcd;

	// ------------------------------------------------------------
	// watchdog state codes and pulse timing
	// ------------------------------------------------------------
	localparam logic [2:0] WD_TEST_HUNT      = 3'h1;
	localparam logic [2:0] WD_RUN_HUNT       = 3'h4;
	localparam int         CLK_MHZ           = 250;
	localparam int         PULSE_NOM_US      = 2000;
	localparam int         PULSE_OFS_BASE_US = 80;   // 0.08 ms at code 0
	localparam int         PULSE_OFS_STEP_US = 10;   // 0.01 ms per code
	localparam int         PULSE_NOM_CYC     = PULSE_NOM_US * CLK_MHZ;
	localparam int         OFS_BASE_CYC      = PULSE_OFS_BASE_US * CLK_MHZ;
	localparam int         OFS_STEP_CYC      = PULSE_OFS_STEP_US * CLK_MHZ;

	// ------------------------------------------------------------
	// serial frame layout
	// ------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS        = 5'd16;
	localparam logic [4:0] HEAD_BITS         = 5'd8;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic switch_node_healthy;
		logic watchdog_fault_flag;
		logic overtemperature_flag;
		logic charge_pump_healthy;
		logic prereg_healthy;
		logic rail_3p3_healthy;
		logic adjustable_rail_healthy;
	} ssr_health_t;

	typedef struct packed {
		logic       reset_demand;        // internal demanded reset level
		logic       reset_output_pin;    // sensed reset pin level
		logic       double_error;        // high on double bit error
		logic       battery_enable_pin;
		logic [2:0] pulse_watchdog_state_code;
	} ssr_pins_t;

	typedef struct packed {
		logic [1:0] watchdog_type_select;
		logic [2:0] pulse_upper_offset;
		logic [2:0] pulse_lower_offset;
	} ssr_wdog_cfg_t;

endpackage

// ---- design/ssr_regs.sv ----
// supervisor status, diagnostic and configuration registers on a serial port
// assumes serial pins are already synchronous to ref_clk_i; frame of 16 bits,
// address 15:11, write flag 10, data 7:0, clock idles low, sampled on rise
`timescale 1ns/10ps

module ssr_regs
	import ssr_pkg::*;
#(
	parameter int NOM_CYC = PULSE_NOM_CYC   // nominal 2 ms pulse in cycles
)
(
	// clock and reset
	input  wire logic          ref_clk_i,
	input  wire logic          resetn_i,
	// serial port
	input  wire logic          strobe_n_i,
	input  wire logic          sck_i,
	input  wire logic          sdi_i,
	output logic               sdo_o,
	output logic               sdo_oe_o,
	// live health and pin levels
	input  wire ssr_health_t   health_i,
	input  wire ssr_pins_t     pins_i,
	input  wire logic          power_enable_req_i,
	// monitor events
	input  wire logic [7:0]    five_v_event_i,
	input  wire logic [7:0]    core_event_i,
	input  wire logic [3:0]    int_event_i,
	input  wire logic [2:0]    rail_above_under_i, // protected, A, B
	// watchdog side
	input  wire logic          watchdog_first_pulse_i,
	output ssr_wdog_cfg_t      wdog_cfg_o,
	output logic [19:0]        pulse_upper_cycles_o,
	output logic [19:0]        pulse_lower_cycles_o,
	output logic               flash_mode_o,
	output logic               watchdog_restart_o,
	// rail and pin control
	output logic [2:0]         rail_off_o,         // protected, A, B
	output logic               power_enable_output_o,
	output logic               general_fault_flag_o
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_GOT2} ssr_key_t;

	logic          sck_q;          // previous serial clock
	logic          strobe_n_q;     // previous strobe
	logic [4:0]    bit_cnt_q;      // bits received this frame
	logic [15:0]   rx_q;           // incoming shift register
	logic [15:0]   tx_q;           // outgoing word
	logic          sdo_q;          // serial data out flop
	logic          sck_rise;
	logic          sck_fall;
	logic          frame_start;
	logic          frame_end;
	logic          wr_commit;      // complete write frame
	logic [4:0]    wr_addr;
	logic [7:0]    wr_data;
	logic [4:0]    rd_addr;
	logic [7:0]    rd_data;        // combinational read mux
	logic [7:0]    shutoff_q;      // rail shutoff pairs
	ssr_wdog_cfg_t cfg_q;          // software configuration
	ssr_wdog_cfg_t applied_q;      // configuration the watchdog runs
	ssr_key_t      key_q;
	logic          flash_q;
	logic          restart_q;
	logic [2:0]    rail_off;       // protected, A, B
	logic [7:0]    five_v_set;
	logic [7:0]    five_v_clr;
	logic [7:0]    core_clr;
	logic [3:0]    int_clr;
	logic [7:0]    five_v_q;
	logic [7:0]    core_q;
	logic [3:0]    int_q;
	logic [7:0]    fault_mask;     // hides expected under flags
	logic          fault_q;
	logic          pwr_en_q;
	logic [19:0]   upper_q;
	logic [19:0]   lower_q;
	logic          in_hunt;

	// ------------------------------------------------------------
	// serial edges and frame framing
	// ------------------------------------------------------------
	assign sck_rise    = !strobe_n_i && sck_i && !sck_q;
	assign sck_fall    = !strobe_n_i && !sck_i && sck_q;
	assign frame_start = strobe_n_q && !strobe_n_i;
	assign frame_end   = !strobe_n_q && strobe_n_i;
	assign wr_addr     = rx_q[15:11];
	assign wr_data     = rx_q[7:0];
	// a short or long frame is dropped whole, never half-written
	assign wr_commit   = frame_end && (bit_cnt_q == FRAME_BITS) && rx_q[10];
	// after eight bits the address sits in the low byte of rx
	assign rd_addr     = rx_q[7:3];

	// edge history
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			sck_q      <= 1'b0;
			strobe_n_q <= 1'b1;
		end
		else
		begin
			sck_q      <= sck_i;
			strobe_n_q <= strobe_n_i;
		end
	end

	// receive shifter and bit counter
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			bit_cnt_q <= 5'd0;
			rx_q      <= 16'h0000;
		end
		else if (frame_start)
		begin
			bit_cnt_q <= 5'd0;
		end
		else if (sck_rise)
		begin
			rx_q <= {rx_q[14:0], sdi_i};
			// saturate so overlong frames stay invalid
			if (bit_cnt_q != 5'h1f)
			begin
				bit_cnt_q <= bit_cnt_q + 5'd1;
			end
		end
	end

	// outgoing word: fault flag first, read data after the header
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			tx_q <= 16'h0000;
		end
		else if (frame_start)
		begin
			tx_q <= {fault_q, 15'h0000};
		end
		else if (bit_cnt_q == HEAD_BITS && !sck_rise && sck_q)
		begin
			// reloaded every cycle while sck_q is still high after bit 8
			tx_q[7:0] <= rd_data;
		end
	end

	// serial output flop, changes on falling clock
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			sdo_q <= 1'b0;
		end
		else if (frame_start)
		begin
			sdo_q <= fault_q;
		end
		else if (sck_fall && bit_cnt_q < FRAME_BITS)
		begin
			sdo_q <= tx_q[4'(15 - 32'(bit_cnt_q))];
		end
	end

	assign sdo_o    = sdo_q;
	assign sdo_oe_o = !strobe_n_i; // driven only inside a frame

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rd_data = 8'h00; // unmapped addresses read zero
		unique case (rd_addr)
			ADDR_RAIL_HEALTH:
			begin
				rd_data = {health_i.switch_node_healthy,
				           pins_i.reset_output_pin == pins_i.reset_demand,
				           health_i.watchdog_fault_flag,
				           health_i.overtemperature_flag,
				           health_i.charge_pump_healthy,
				           health_i.prereg_healthy,
				           health_i.rail_3p3_healthy,
				           health_i.adjustable_rail_healthy};
			end
			ADDR_PIN_WDOG:
			begin
				rd_data = {1'b0,
				           !pins_i.double_error,
				           pins_i.reset_demand,
				           pwr_en_q,
				           pins_i.battery_enable_pin,
				           pins_i.pulse_watchdog_state_code};
			end
			ADDR_FIVE_V_LATCH: rd_data = five_v_q;
			ADDR_CORE_LATCH:   rd_data = core_q;
			ADDR_INT_LATCH:    rd_data = {4'h0, int_q};
			ADDR_SHUTOFF:      rd_data = shutoff_q;
			ADDR_UNLOCK:       rd_data = {7'h00, flash_q};       // unlocked bit
			ADDR_WDOG_CFG:     rd_data = cfg_q;
			default:           rd_data = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// rail shutoff pairs
	// ------------------------------------------------------------
	// two bits per rail so a single upset bit cannot drop a rail
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			shutoff_q <= SHUTOFF_RST;
		end
		else if (wr_commit && wr_addr == ADDR_SHUTOFF)
		begin
			shutoff_q <= wr_data & SHUTOFF_MASK;
		end
	end

	assign rail_off[2] = shutoff_q[OFF_PROT_HI] & shutoff_q[OFF_PROT_LO];
	assign rail_off[1] = shutoff_q[OFF_A_HI] & shutoff_q[OFF_A_LO];
	assign rail_off[0] = shutoff_q[OFF_B_HI] & shutoff_q[OFF_B_LO];
	assign rail_off_o  = rail_off;

	// ------------------------------------------------------------
	// sticky diagnostic flags
	// ------------------------------------------------------------
	// a disabled rail is forced into under, or over if it stays up
	always_comb
	begin
		five_v_set             = five_v_event_i;
		five_v_set[PROT_UNDER] = five_v_event_i[PROT_UNDER]
		                       | (rail_off[2] & !rail_above_under_i[2]);
		five_v_set[PROT_OVER]  = five_v_event_i[PROT_OVER]
		                       | (rail_off[2] & rail_above_under_i[2]);
		five_v_set[A_UNDER]    = five_v_event_i[A_UNDER]
		                       | (rail_off[1] & !rail_above_under_i[1]);
		five_v_set[A_OVER]     = five_v_event_i[A_OVER]
		                       | (rail_off[1] & rail_above_under_i[1]);
		five_v_set[B_UNDER]    = five_v_event_i[B_UNDER]
		                       | (rail_off[0] & !rail_above_under_i[0]);
		five_v_set[B_OVER]     = five_v_event_i[B_OVER]
		                       | (rail_off[0] & rail_above_under_i[0]);
	end

	// clear masks from a write of ones
	assign five_v_clr = (wr_commit && wr_addr == ADDR_FIVE_V_LATCH) ? wr_data : 8'h00;
	assign core_clr   = (wr_commit && wr_addr == ADDR_CORE_LATCH) ? wr_data : 8'h00;
	assign int_clr    = (wr_commit && wr_addr == ADDR_INT_LATCH) ?
	                    wr_data[3:0] & INT_LATCH_MASK[3:0] : 4'h0;

	// five volt rails
	ssr_flag_latch #(.W(8)) u_five_v
	(
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.set_i     (five_v_set),
		.clr_i     (five_v_clr),
		.q_o       (five_v_q)
	);

	// core rails
	ssr_flag_latch #(.W(8)) u_core
	(
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.set_i     (core_event_i),
		.clr_i     (core_clr),
		.q_o       (core_q)
	);

	// internal supply and charge pump
	ssr_flag_latch #(.W(4)) u_int
	(
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.set_i     (int_event_i),
		.clr_i     (int_clr),
		.q_o       (int_q)
	);

	// ------------------------------------------------------------
	// general fault flag
	// ------------------------------------------------------------
	// under flags of rails the host turned off are expected, so hidden
	always_comb
	begin
		fault_mask             = 8'hff;
		fault_mask[PROT_UNDER] = !rail_off[2];
		fault_mask[A_UNDER]    = !rail_off[1];
		fault_mask[B_UNDER]    = !rail_off[0];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			fault_q <= 1'b0;
		end
		else
		begin
			fault_q <= |(five_v_q & fault_mask) | |core_q | |int_q;
		end
	end

	assign general_fault_flag_o = fault_q;

	// ------------------------------------------------------------
	// unlock key sequence
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			key_q     <= KEY_IDLE;
			flash_q   <= 1'b0;
			restart_q <= 1'b0;
		end
		else
		begin
			restart_q <= 1'b0;
			if (wr_commit && wr_addr == ADDR_UNLOCK)
			begin
				unique case (key_q)
					KEY_IDLE:
					begin
						key_q <= (wr_data == KEY_WORD1) ? KEY_GOT1 : KEY_IDLE;
					end
					KEY_GOT1:
					begin
						key_q <= (wr_data == KEY_WORD2) ? KEY_GOT2 : KEY_IDLE;
					end
					KEY_GOT2:
					begin
						key_q <= KEY_IDLE; // third word ends the sequence either way
						if (wr_data == KEY_FLASH)
						begin
							flash_q <= 1'b1;
						end
						else if (wr_data == KEY_RESTART)
						begin
							flash_q   <= 1'b0;
							restart_q <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	assign flash_mode_o       = flash_q;
	assign watchdog_restart_o = restart_q;

	// power enable forced low in flash; other supplies untouched
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			pwr_en_q <= 1'b0;
		end
		else
		begin
			pwr_en_q <= power_enable_req_i && !flash_q;
		end
	end

	assign power_enable_output_o = pwr_en_q;

	// ------------------------------------------------------------
	// watchdog configuration
	// ------------------------------------------------------------
	// software copy accepts writes at any time
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			cfg_q <= WDOG_CFG_RST;
		end
		else if (wr_commit && wr_addr == ADDR_WDOG_CFG)
		begin
			cfg_q <= wr_data;
		end
	end

	assign in_hunt = pins_i.pulse_watchdog_state_code == WD_TEST_HUNT
	              || pins_i.pulse_watchdog_state_code == WD_RUN_HUNT;

	// running copy follows only on a hunt pulse or a restart
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			applied_q <= WDOG_CFG_RST;
		end
		else if ((in_hunt && watchdog_first_pulse_i) || restart_q)
		begin
			applied_q <= cfg_q;
		end
	end

	// type select is bits 7..6 of the running copy
	assign wdog_cfg_o = applied_q;

	// pulse limits in cycles from the running offsets
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			upper_q <= 20'h00000;
			lower_q <= 20'h00000;
		end
		else
		begin
			upper_q <= 20'(NOM_CYC + OFS_BASE_CYC
			               + 32'(applied_q.pulse_upper_offset) * OFS_STEP_CYC);
			lower_q <= 20'(NOM_CYC - OFS_BASE_CYC
			               - 32'(applied_q.pulse_lower_offset) * OFS_STEP_CYC);
		end
	end

	assign pulse_upper_cycles_o = upper_q;
	assign pulse_lower_cycles_o = lower_q;

endmodule

// ---- tb/ssr_host.sv ----
// host controller model driving 16-bit serial frames
// assumes sck idles low, data taken on its rise, sdo settles after its fall
`timescale 1ns/10ps

module ssr_host
(
	// clock
	input  wire logic ref_clk_i,
	// serial pins
	output logic      strobe_n_o,
	output logic      sck_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	int   half_q = 3;   // sck half period, 3 or more keeps sdo sampling safe
	logic sdo_q;        // sdo taken clear of the rising edge

	// idle pins at time zero
	initial
	begin
		strobe_n_o = 1'b1;
		sck_o      = 1'b0;
		sdi_o      = 1'b0;
	end

	// sample mid-cycle so the design's edge update never races us
	always @(negedge ref_clk_i)
		sdo_q <= sdo_i;

	// one whole frame, msb first; writes and key words come from the caller
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(posedge ref_clk_i);
		strobe_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdi_o <= w[i];
			repeat (half_q) @(posedge ref_clk_i);
			r[i] = sdo_q;
			sck_o <= 1'b1;
			repeat (half_q) @(posedge ref_clk_i);
			sck_o <= 1'b0;
		end
		repeat (half_q) @(posedge ref_clk_i);
		strobe_n_o <= 1'b1;
		sdi_o      <= ~w[0];   // released line shows no stale bit
		repeat (3) @(posedge ref_clk_i);
	endtask
endmodule

// ---- tb/ssr_regs_checker.sv ----
// port-level checks for the supervisor register bank
// assumes one clock and the synchronous active-low reset of ssr_regs
`timescale 1ns/10ps

module ssr_regs_checker
	import ssr_pkg::*;
#(
	parameter int NOM_CYC = PULSE_NOM_CYC   // nominal pulse in cycles
)
(
	// clock and reset
	input  wire logic          ref_clk_i,
	input  wire logic          resetn_i,
	// inputs of interest
	input  wire logic          strobe_n_i,
	input  wire logic          power_enable_req_i,
	input  wire logic [2:0]    rail_above_under_i,
	input  wire logic          watchdog_first_pulse_i,
	// outputs watched
	input  wire ssr_wdog_cfg_t wdog_cfg_o,
	input  wire logic [19:0]   pulse_upper_cycles_o,
	input  wire logic [19:0]   pulse_lower_cycles_o,
	input  wire logic          flash_mode_o,
	input  wire logic          watchdog_restart_o,
	input  wire logic [2:0]    rail_off_o,
	input  wire logic          power_enable_output_o,
	input  wire logic          general_fault_flag_o
);
	// ------
	// helpers
	// ------
	logic str_q;     // strobe one cycle back
	logic str_qq;    // strobe two cycles back
	logic alive_q;   // reset released on the previous edge
	// register effects may only land the cycle after a frame ends
	wire  cmt = str_q && !str_qq;

	// delay line for strobe and reset
	always_ff @(posedge ref_clk_i)
	begin
		str_q   <= strobe_n_i;
		str_qq  <= str_q;
		alive_q <= resetn_i;
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_off_commit;
		$changed(rail_off_o) |-> cmt;
	endproperty
	a_off_commit: assert property (p_off_commit)
		else $error("rail off changed outside a write");
	property p_flash_commit;
		$rose(flash_mode_o) |-> cmt;
	endproperty
	a_flash_commit: assert property (p_flash_commit)
		else $error("flash entered outside a write");
	property p_restart_pulse;
		watchdog_restart_o |-> cmt;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse)
		else $error("restart pulse not right after a write");
	property p_pe_flash;
		flash_mode_o ##1 flash_mode_o |-> !power_enable_output_o;
	endproperty
	a_pe_flash: assert property (p_pe_flash)
		else $error("power enable high in flash mode");
	property p_pe_follow;
		alive_q && $past(power_enable_req_i) && !$past(flash_mode_o) && !flash_mode_o
			|-> power_enable_output_o;
	endproperty
	a_pe_follow: assert property (p_pe_follow)
		else $error("power enable lost outside flash");
	property p_cfg_apply;
		$changed(wdog_cfg_o) |-> $past(watchdog_first_pulse_i) || $past(watchdog_restart_o)
			|| $past(watchdog_restart_o, 2);
	endproperty
	a_cfg_apply: assert property (p_cfg_apply)
		else $error("watchdog config applied without cause");
	property p_upper;
		alive_q && $stable(wdog_cfg_o) |-> pulse_upper_cycles_o ==
			20'(NOM_CYC + OFS_BASE_CYC + OFS_STEP_CYC * wdog_cfg_o.pulse_upper_offset);
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper pulse limit wrong");
	property p_lower;
		alive_q && $stable(wdog_cfg_o) |-> pulse_lower_cycles_o ==
			20'(NOM_CYC - OFS_BASE_CYC - OFS_STEP_CYC * wdog_cfg_o.pulse_lower_offset);
	endproperty
	a_lower: assert property (p_lower)
		else $error("lower pulse limit wrong");
	property p_over_fault;
		|(rail_off_o & rail_above_under_i) |-> ##[1:2] general_fault_flag_o;
	endproperty
	a_over_fault: assert property (p_over_fault)
		else $error("disabled rail above threshold without fault");
endmodule

bind ssr_regs ssr_regs_checker #(.NOM_CYC(NOM_CYC)) ssr_regs_checker_i (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .strobe_n_i(strobe_n_i),
	.power_enable_req_i(power_enable_req_i), .rail_above_under_i(rail_above_under_i),
	.watchdog_first_pulse_i(watchdog_first_pulse_i), .wdog_cfg_o(wdog_cfg_o),
	.pulse_upper_cycles_o(pulse_upper_cycles_o), .pulse_lower_cycles_o(pulse_lower_cycles_o),
	.flash_mode_o(flash_mode_o), .watchdog_restart_o(watchdog_restart_o),
	.rail_off_o(rail_off_o), .power_enable_output_o(power_enable_output_o),
	.general_fault_flag_o(general_fault_flag_o));

// ---- tb/ssr_regs_tb_top.sv ----
// self-checking bench for the supervisor register bank
// assumes the host model above and the bound checker
`timescale 1ns/10ps

module ssr_regs_tb_top;
	import ssr_pkg::*;
	logic          ref_clk, resetn, strobe_n, sck, sdi, sdo, sdo_oe;
	logic          pe_req, first_pulse, flash, restart, pe_out, fault;
	ssr_health_t   health;
	ssr_pins_t     pins;
	ssr_wdog_cfg_t cfg;
	logic [7:0]    ev5, evc, v, e, c, m, ecfg;
	logic [3:0]    evi;
	logic [2:0]    above, rail_off;
	logic [19:0]   upper, lower;
	logic [15:0]   rw;
	logic [31:0]   seed = 32'h3;
	logic [5:0]    fl = 6'h11;   // flash expected after each key sequence
	logic [31:0]   keys [6] = '{32'h00d333cc, 32'h00d333cd, 32'hd31233cc,
		32'hd3d333cc, 32'h00d333cc, 32'h00d333cd};
	logic [7:0]    cor [4] = '{8'h88, 8'h80, 8'h08, 8'hff};
	int            n_mismatch, n_compared, i, k;

	ssr_regs ssr_regs_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .strobe_n_i(strobe_n),
		.sck_i(sck), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .health_i(health),
		.pins_i(pins), .power_enable_req_i(pe_req), .five_v_event_i(ev5),
		.core_event_i(evc), .int_event_i(evi), .rail_above_under_i(above),
		.watchdog_first_pulse_i(first_pulse), .wdog_cfg_o(cfg),
		.pulse_upper_cycles_o(upper), .pulse_lower_cycles_o(lower), .flash_mode_o(flash),
		.watchdog_restart_o(restart), .rail_off_o(rail_off),
		.power_enable_output_o(pe_out), .general_fault_flag_o(fault));
	ssr_host ssr_host_i (.ref_clk_i(ref_clk), .strobe_n_o(strobe_n), .sck_o(sck),
		.sdi_o(sdi), .sdo_i(sdo));

	// 250 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected status words from the live inputs
	function automatic logic [7:0] exp_rail();
		return {health[6], pins.reset_output_pin ~^ pins.reset_demand, health[5:0]};
	endfunction
	function automatic logic [7:0] exp_pin();
		return {1'b0, ~pins.double_error, pins.reset_demand, pe_req,
			pins.battery_enable_pin, pins.pulse_watchdog_state_code};
	endfunction

	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] got);
		n_compared++;
		if (got !== x)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, x, got);
		end
	endtask
	// read; header bits 14..8 and the idle enable are zero
	task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] x);
		ssr_host_i.xfer({a, 11'h000}, rw);
		chk(nm, 16'(x), {sdo_oe, rw[14:0]});
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		ssr_host_i.xfer({a, 3'h4, d}, rw);
	endtask
	// one-cycle event into latch k
	task automatic fire(input int k, input logic [7:0] x);
		@(posedge ref_clk);
		if (k == 0) ev5 <= x;
		if (k == 1) evc <= x;
		if (k == 2) evi <= x[3:0];
		@(posedge ref_clk);
		{ev5, evc, evi} <= 20'h00000;
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		end_sim();
	end

	// ------
	// main sequence
	// ------
	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		resetn = 1'b0;
		{health, pins, pe_req, first_pulse, above} = '0;
		{ev5, evc, evi} = 20'h00000;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rc("cfg_rst", ADDR_WDOG_CFG, 8'h24);
		chk("cfg_o_rst", 16'h0024, 16'(cfg));
		for (k = 3; k < 7; k++)
			rc("reg_rst", 5'(k), 8'h00);
		// live status, all state codes, varied host speed
		for (i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			health <= 7'(rnd());
			pins   <= {4'(rnd()), 3'(i)};
			pe_req <= 1'(rnd());
			ssr_host_i.half_q = 3 + i % 3;
			@(posedge ref_clk);
			rc("status_rail", ADDR_RAIL_HEALTH, exp_rail());
			rc("status_pin", ADDR_PIN_WDOG, exp_pin());
		end
		// sticky flags: set, partial clear, full clear
		for (k = 0; k < 3; k++)
		begin
			e = 8'(rnd()) | 8'h01;
			m = (k == 2) ? 8'h0f : 8'hff;
			c = 8'(rnd());
			fire(k, e);
			rc("latch_set", 5'(3 + k), e & m);
			wr(5'(3 + k), c);
			rc("latch_w1c", 5'(3 + k), e & m & ~c);
			wr(5'(3 + k), 8'hff);
		end
		// rail shutoff pairs, corners first
		for (i = 0; i < 14; i++)
		begin
			v = (i < 4) ? cor[i] : 8'(rnd());
			@(posedge ref_clk);
			above <= 3'(rnd());
			wr(ADDR_SHUTOFF, v);
			chk("rail_off", 16'({v[7] & v[3], v[6] & v[2], v[5] & v[1]}), 16'(rail_off));
			rc("shutoff_rb", ADDR_SHUTOFF, v & 8'hee);
		end
		@(posedge ref_clk);
		above <= 3'h0;
		wr(ADDR_SHUTOFF, 8'h00);
		for (k = 3; k < 6; k++)
			wr(5'(k), 8'hff);
		// disabled rail: expected undervoltage, then stuck high
		wr(ADDR_SHUTOFF, 8'h44);
		rc("dis_under", ADDR_FIVE_V_LATCH, 8'h40);
		chk("fault_quiet", 16'h0000, 16'(fault));
		@(posedge ref_clk);
		above <= 3'h2;
		rc("dis_over", ADDR_FIVE_V_LATCH, 8'hc0);
		chk("fault_over", 16'h0001, 16'(fault));
		@(posedge ref_clk);
		above <= 3'h0;
		wr(ADDR_SHUTOFF, 8'h00);
		wr(ADDR_FIVE_V_LATCH, 8'hff);
		chk("fault_clear", 16'h0002, 16'({rw[15], fault}));
		// key sequences; config waits for the restart
		pe_req <= 1'b1;
		wr(ADDR_WDOG_CFG, 8'h9b);
		rc("cfg_rb", ADDR_WDOG_CFG, 8'h9b);
		chk("cfg_held", 16'h0024, 16'(cfg));
		for (i = 0; i < 6; i++)
		begin
			for (k = 3; k >= 0; k--)
				wr(ADDR_UNLOCK, keys[i][8 * k +: 8]);
			chk("flash", 16'(fl[i]), 16'(flash));
			rc("key_rb", ADDR_UNLOCK, 8'(fl[i]));
			chk("power_en", 16'(!fl[i]), 16'(pe_out));
		end
		chk("cfg_restart", 16'h009b, 16'(cfg));
		// every watchdog type, applied only on a hunt pulse
		ecfg = 8'h9b;
		for (i = 0; i < 6; i++)
		begin
			v = {2'(i), 6'(rnd())};
			wr(ADDR_WDOG_CFG, v);
			@(posedge ref_clk);
			pins.pulse_watchdog_state_code <= (i < 4) ? (i[0] ? WD_RUN_HUNT : WD_TEST_HUNT) : 3'(i - 2);
			first_pulse <= 1'b1;
			@(posedge ref_clk);
			first_pulse <= 1'b0;
			repeat (2) @(posedge ref_clk);
			if (i < 4)
				ecfg = v;
			chk("cfg_apply", 16'(ecfg), 16'(cfg));
		end
		end_sim();
	end
endmodule
